/* core/srp_pkg.sv */
/*
 * constants, state encoding and timing counts of the serial register port.
 * assumes a single 200 MHz core clock; the host drives the serial pins.
 */
package srp_pkg;

    // frame layout, msb first: payload, register index, chip code
    localparam int          FRAME_BITS   = 40;
    localparam int          PAYLOAD_BITS = 30;
    localparam int          INDEX_BITS   = 7;
    localparam int          CODE_BITS    = 3;
    localparam int          CNT_BITS     = 6;   // holds 0..40
    localparam logic [5:0]  FRAME_LEN    = 6'h28;
    localparam int          IDX_LSB      = 3;   // index position in frame
    localparam int          PAYLOAD_LSB  = 10;  // payload position in frame

    // this device answers only to chip code 111b
    localparam logic [2:0]  CHIP_CODE    = 3'h7;

    // register 0: read pointer in [6:0], soft reset in [7]
    localparam logic [6:0]  CTRL_REG     = 7'h00;
    localparam int          SOFT_RST_BIT = 7;
    localparam int          CTRL_BITS    = 8;
    localparam logic [7:0]  CTRL_DEFAULT = 8'h00;
    localparam logic [29:0] REG_DEFAULT  = 30'h0000_0000;

    // power-on reset delay, counted in core clock cycles
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          POR_TIME_US   = 250;
    localparam int          POR_CYCLES    =
        POR_TIME_US * 1000 * 1000 / CLK_PERIOD_PS;

    // frame sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_RESET = 3'h1,   // power-on delay running
        ST_IDLE  = 3'h2,   // select high, waiting for a frame
        ST_FRAME = 3'h4    // select low, bits moving
    } srp_state_e;

endpackage

/* core/srp_evt_if.sv */
/*
 * events carried from the pin synchroniser to the frame logic.
 * assumes both ends run on core_clk; every pulse is one core cycle wide.
 */
`timescale 1ns/1ps
interface srp_evt_if;
    logic sck_rise;    // pulse: serial clock rising edge seen
    logic sel_active;  // level: port select held low
    logic sel_start;   // pulse: port select fell
    logic sel_end;     // pulse: port select rose
    logic sdi_bit;     // level: input line, aligned with sck_rise

    modport src (output sck_rise, sel_active, sel_start, sel_end, sdi_bit);
    modport dst (input  sck_rise, sel_active, sel_start, sel_end, sdi_bit);
endinterface

/* core/srp_pin_sync.sv */
/*
 * two-flop synchronisers and edge detection for the serial pins.
 * assumes pins are asynchronous to core_clk and the serial clock runs
 * well below a quarter of the core clock.
 */
`timescale 1ns/1ps
module srp_pin_sync (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic sck,
    input  wire logic port_select_n,
    input  wire logic sdi,
    srp_evt_if.src    evt
);

    // stage 1 feeds stage 2 only; edges compare stage 2 with stage 3
    typedef struct packed {
        logic [2:0] meta;   // first flops: {sck, select, sdi}
        logic [2:0] sync;   // second flops
        logic [1:0] prev;   // delayed {sck, select} for edges
    } srp_sync_s;

    localparam srp_sync_s SYNC_RST = '{meta: 3'h2, sync: 3'h2, prev: 2'h1};

    srp_sync_s st;       // registered state
    srp_sync_s next_st;  // next value

    // shift the pins through the chain
    always_comb begin
        next_st      = st;
        next_st.meta = {sck, port_select_n, sdi};
        next_st.sync = st.meta;
        next_st.prev = st.sync[2:1];
    end

    // select idles high so a reset never fakes a frame start
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st <= SYNC_RST;
        end else begin
            st <= next_st;
        end
    end

    // sdi shares the sck latency, so it is valid on the rising event
    assign evt.sck_rise   = st.sync[2] & ~st.prev[1];
    assign evt.sel_active = ~st.sync[1];
    assign evt.sel_start  = ~st.sync[1] & st.prev[0];
    assign evt.sel_end    = st.sync[1] & ~st.prev[0];
    assign evt.sdi_bit    = st.sync[0];

endmodule

/* core/srp_core.sv */
/*
 * serial register port: 40-bit frames, readback through a read pointer,
 * soft reset through register 0 and a power-on reset delay.
 * assumes the host is the serial master; sdo is a tri-state pin resolved
 * outside from sdo and sdo_oe.
 */
`timescale 1ns/1ps
// Behaviour
// [RL1] every frame is forty serial clocks
// [RL2] input bits sampled on rising serial clock
// [RL3] first rising edge after select captures msb
// [RL4] thirty payload bits captured first, msb first
// [RL5] seven index bits follow, msb first
// [RL6] last three bits are chip code 111
// [RL7] select rise after forty edges commits write
// [RL8] host reads using two frames via register 0
// [RL9] host puts index in payload, zero index
// [RL10] readback shifts data, index, code msb first
// [RL11] output changes on rising, host samples falling
// [RL12] output driven only in frame after addressing
// [RL13] read frame payload also stored on select rise
// [RL14] host addresses register 0 in readback frame
// [RL15] host keeps select low for forty bits
// [RL16] writing 80h then 00h soft resets
// [RL17] power-on reset delay about 250 us
// [RL18] register 0 bit 7 holds soft reset
// [RL19] register 0 bits 6..0 are read pointer
// [RL20] wrong chip code frames are ignored
module srp_core #(
    parameter int          NUM_REGS   = 32,               // stored registers
    parameter int          POR_CYCLES = srp_pkg::POR_CYCLES,
    parameter logic [21:0] CHIP_ID    = 22'h15A5A5        // arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        sck,
    input  wire logic        port_select_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    output logic             reg_wr_pulse,
    output logic [6:0]       reg_wr_index,
    output logic [29:0]      reg_wr_data,
    output logic             core_reset
);

    srp_evt_if evt ();  // synchronised pin events

    srp_pin_sync u_sync (
        .core_clk      (core_clk),
        .resetn        (resetn),
        .sck           (sck),
        .port_select_n (port_select_n),
        .sdi           (sdi),
        .evt           (evt)
    );

    // whole state of the frame logic and its register file
    typedef struct packed {
        srp_pkg::srp_state_e         fsm;        // sequencer state
        logic [31:0]                 por_cnt;    // power-on delay count
        logic [5:0]                  bit_cnt;    // rising edges this frame
        logic [39:0]                 in_sr;      // frame shifted in
        logic [39:0]                 out_sr;     // readback shifted out
        logic                        sdo;        // output pin value
        logic                        sdo_oe;     // output pin enable
        logic                        addressed;  // last frame was ours
        logic [7:0]                  ctrl;       // register 0 contents
        logic [NUM_REGS-1:0][29:0]   regs;       // registers 1 and up
        logic                        wr_pulse;   // commit strobe
        logic [6:0]                  wr_index;   // committed index
        logic [29:0]                 wr_data;    // committed payload
    } srp_core_s;

    localparam srp_core_s CORE_RST = '{
        fsm:      srp_pkg::ST_RESET,
        por_cnt:  32'h0000_0000,
        bit_cnt:  6'h00,
        in_sr:    40'h00_0000_0000,
        out_sr:   40'h00_0000_0000,
        sdo:      1'b0,
        sdo_oe:   1'b0,
        addressed: 1'b0,
        ctrl:     srp_pkg::CTRL_DEFAULT,
        regs:     {NUM_REGS{srp_pkg::REG_DEFAULT}},
        wr_pulse: 1'b0,
        wr_index: 7'h00,
        wr_data:  30'h0000_0000
    };

    srp_core_s st;       // registered state
    srp_core_s next_st;  // next value

    // word returned for a register index; register 0 carries the id on top
    function automatic logic [29:0] read_word(input srp_core_s s,
                                              input logic [6:0] idx);
        logic [29:0] w;
        w = srp_pkg::REG_DEFAULT;
        if (idx == srp_pkg::CTRL_REG) begin
            w = {CHIP_ID, s.ctrl};
        end else if (32'(idx) < NUM_REGS) begin
            w = s.regs[idx];
        end
        return w;
    endfunction

    wire logic [6:0] rx_index = st.in_sr[srp_pkg::IDX_LSB +: 7];   // see [RL5]
    wire logic [2:0] rx_code  = st.in_sr[2:0];                     // see [RL6]
    wire logic       rx_valid = (st.bit_cnt == srp_pkg::FRAME_LEN) &&
                                (rx_code == srp_pkg::CHIP_CODE);

    // frame sequencing, register commit, readback and reset handling
    always_comb begin
        next_st          = st;
        next_st.wr_pulse = 1'b0;
        case (st.fsm)
            srp_pkg::ST_RESET: begin
                // registers stay at defaults until the delay expires
                next_st.por_cnt = st.por_cnt + 32'h0000_0001;
                if (st.por_cnt == 32'(POR_CYCLES - 1)) begin  // see [RL17]
                    next_st.fsm = srp_pkg::ST_IDLE;
                end
            end
            srp_pkg::ST_IDLE: begin
                if (evt.sel_start) begin                      // see [RL3]
                    next_st.fsm     = srp_pkg::ST_FRAME;
                    next_st.bit_cnt = 6'h00;
                    next_st.sdo     = 1'b0;
                    // drive only when the previous frame was ours
                    next_st.sdo_oe  = st.addressed;           // see [RL12]
                    // pointer picks the word, then index and code
                    next_st.out_sr  = {read_word(st, st.ctrl[6:0]),
                                       st.ctrl[6:0],
                                       srp_pkg::CHIP_CODE};   // see [RL10] [RL19]
                end
            end
            srp_pkg::ST_FRAME: begin
                if (evt.sel_end) begin
                    next_st.fsm       = srp_pkg::ST_IDLE;
                    next_st.sdo       = 1'b0;
                    next_st.sdo_oe    = 1'b0;
                    // short or foreign frames leave nothing behind; clocks past forty are ignored
                    next_st.addressed = rx_valid;             // see [RL20]
                    if (rx_valid) begin                       // see [RL7] [RL13]
                        next_st.wr_pulse = 1'b1;
                        next_st.wr_index = rx_index;
                        next_st.wr_data  = st.in_sr[39:srp_pkg::PAYLOAD_LSB];
                        if (rx_index == srp_pkg::CTRL_REG) begin
                            next_st.ctrl = st.in_sr[17:10];   // see [RL18]
                        end else if (32'(rx_index) < NUM_REGS) begin
                            next_st.regs[rx_index] = st.in_sr[39:10];
                        end
                    end
                end
            end
            default: begin
                next_st = CORE_RST;
            end
        endcase

        // rising serial edge: take one input bit, and present one output bit while sdo_oe is set
        if (next_st.fsm == srp_pkg::ST_FRAME && !evt.sel_end &&
            evt.sck_rise && next_st.bit_cnt < srp_pkg::FRAME_LEN) begin // see [RL1]
            next_st.in_sr   = {next_st.in_sr[38:0], evt.sdi_bit}; // see [RL2] [RL4]
            next_st.bit_cnt = next_st.bit_cnt + 6'h01;
            if (next_st.sdo_oe) begin                         // see [RL11]
                next_st.sdo    = next_st.out_sr[39];
                next_st.out_sr = {next_st.out_sr[38:0], 1'b0};
            end
        end

        // soft reset holds every other register at its default
        if (next_st.ctrl[srp_pkg::SOFT_RST_BIT]) begin        // see [RL16]
            next_st.regs = {NUM_REGS{srp_pkg::REG_DEFAULT}};
        end
    end

    // one register stage for the whole state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st <= CORE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign sdo          = st.sdo;
    assign sdo_oe       = st.sdo_oe;
    assign reg_wr_pulse = st.wr_pulse;
    assign reg_wr_index = st.wr_index;
    assign reg_wr_data  = st.wr_data;
    // downstream logic sits in reset during the delay or a soft reset
    assign core_reset   = (st.fsm == srp_pkg::ST_RESET) ||
                          st.ctrl[srp_pkg::SOFT_RST_BIT];

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_BIT_COUNT_LIMIT: assert property ( // see [RL1]
        st.bit_cnt <= srp_pkg::FRAME_LEN)
        else $error("frame bit count passed forty");

    AST_FIRST_EDGE_CLEARS: assert property ( // see [RL3]
        (st.fsm == srp_pkg::ST_IDLE && evt.sel_start && !evt.sck_rise)
        |=> (st.fsm == srp_pkg::ST_FRAME && st.bit_cnt == 6'h00))
        else $error("frame start did not clear the bit count");

    AST_SAMPLE_ON_RISE: assert property ( // see [RL2]
        (st.fsm == srp_pkg::ST_FRAME && evt.sck_rise && !evt.sel_end &&
         st.bit_cnt < srp_pkg::FRAME_LEN)
        |=> (st.in_sr[0] == $past(evt.sdi_bit) &&
             st.bit_cnt == $past(st.bit_cnt) + 6'h01))
        else $error("rising edge did not capture the input bit");

    AST_COMMIT_VALID: assert property ( // see [RL7]
        (st.fsm == srp_pkg::ST_FRAME && evt.sel_end && rx_valid)
        |=> (st.wr_pulse && st.wr_index == $past(rx_index) &&
             st.wr_data == $past(st.in_sr[39:10])))
        else $error("valid frame was not committed");

    AST_FOREIGN_IGNORED: assert property ( // see [RL20]
        (st.fsm == srp_pkg::ST_FRAME && evt.sel_end && !rx_valid)
        |=> (!st.wr_pulse && !st.addressed)
        ##1 (st.fsm != srp_pkg::ST_FRAME || !st.sdo_oe))
        else $error("foreign frame changed state");

    AST_SDO_ON_RISE: assert property ( // see [RL11]
        $changed(st.sdo) && st.sdo_oe |-> $past(evt.sck_rise))
        else $error("output changed without a rising edge");

    AST_OE_IN_FRAME: assert property ( // see [RL12]
        st.sdo_oe |-> (st.fsm == srp_pkg::ST_FRAME && $past(st.addressed)))
        else $error("output driven outside an addressed frame");

    AST_READBACK_LOAD: assert property ( // see [RL10]
        (st.fsm == srp_pkg::ST_IDLE && evt.sel_start)
        |=> (st.out_sr[2:0] == srp_pkg::CHIP_CODE || evt.sck_rise ||
             $past(evt.sck_rise)))
        else $error("readback word lacks the chip code");

    // same cycle: the write that clears bit 7 lets core_reset fall at once
    AST_SOFT_RESET_HOLD: assert property ( // see [RL16]
        st.ctrl[srp_pkg::SOFT_RST_BIT] |->
        (st.regs == {NUM_REGS{srp_pkg::REG_DEFAULT}} && core_reset))
        else $error("soft reset did not clear registers");

    AST_POR_QUIET: assert property ( // see [RL17]
        (st.fsm == srp_pkg::ST_RESET) |-> (!st.wr_pulse && !st.sdo_oe))
        else $error("activity during power-on delay");

    COV_WRITE: cover property (st.wr_pulse && st.wr_index != 7'h00);
    COV_POINTER: cover property (st.wr_pulse && st.wr_index == 7'h00);
    COV_READBACK: cover property (st.sdo_oe && st.bit_cnt == 6'h28);
    COV_SOFT_RST: cover property (st.ctrl[srp_pkg::SOFT_RST_BIT]);

endmodule

/* testbench/srp_host_model.sv */
/*
 * behavioural serial master that plays the host side of the port.
 * assumes sdo_line is already resolved from sdo and sdo_oe by the bench.
 */
`timescale 1ns/1ps
module srp_host_model (
    output logic sck,
    output logic port_select_n,
    output logic sdi,
    input  wire logic sdo_line,
    input  wire logic sdo_oe
);
    // serial clock stands low and select high between frames
    initial begin
        sck           = 1'b0;
        port_select_n = 1'b1;
        sdi           = 1'b0;
    end

    // one frame of nbits clocks; 24 ns half periods give the 48 ns link clock
    task automatic frame(input logic [39:0] tx, input int nbits,
                         output logic [39:0] rx, output logic oe_seen);
        rx      = '0;
        oe_seen = 1'b0;
        #7;
        port_select_n <= 1'b0;
        sdi           <= tx[39];
        #24;
        for (int i = 0; i < nbits; i++) begin
            sck <= 1'b1;
            #24;
            // host samples the output on the falling edge
            sck <= 1'b0;
            rx[39-i] = sdo_line;
            oe_seen  = oe_seen | sdo_oe;
            // after the last bit the line is driven with that bit inverted
            if (i < nbits - 1) begin
                sdi <= tx[38-i];
            end else begin
                sdi <= ~tx[39-i];
            end
            #24;
        end
        port_select_n <= 1'b1;
        #48;
    endtask
endmodule

/* testbench/testbench.sv */
/*
 * self-checking bench for the serial register port core.
 * assumes the core is built with a short power-on delay of 20 cycles.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    bad_count++; $display("unexpected at %0t: got %h expected %h", \
    $time, (got), (exp)); end end
module testbench;
    localparam int          POR = 20;
    localparam logic [21:0] ID  = 22'h2C3C3C;  // arbitrary value
    logic        core_clk;
    logic        resetn;
    wire         sck;
    wire         port_select_n;
    wire         sdi;
    wire         sdo;
    wire         sdo_oe;
    wire         sdo_line;
    wire         reg_wr_pulse;
    wire [6:0]   reg_wr_index;
    wire [29:0]  reg_wr_data;
    wire         core_reset;
    int          bad_count;
    int          checks_done;
    int          pulses;
    logic [39:0] rx;
    logic        oe;

    srp_core #(.NUM_REGS(4), .POR_CYCLES(POR), .CHIP_ID(ID)) u_dut (
        .core_clk(core_clk), .resetn(resetn), .sck(sck),
        .port_select_n(port_select_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .reg_wr_pulse(reg_wr_pulse),
        .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data),
        .core_reset(core_reset)
    );
    srp_host_model u_host (
        .sck(sck), .port_select_n(port_select_n), .sdi(sdi),
        .sdo_line(sdo_line), .sdo_oe(sdo_oe)
    );

    // tri-state pin: no pull, an undriven line reads z
    assign sdo_line = sdo_oe ? sdo : 1'bz;

    // count commit pulses so tasks can see whether a frame landed
    always @(posedge core_clk) begin
        if (reg_wr_pulse === 1'b1) begin
            pulses++;
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic test_done;
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one frame, then a bounded wait for the commit pulse
    task automatic send(input logic [29:0] d, input logic [6:0] a,
                        input logic [2:0] c, input int n, input bit commit);
        int p0;
        p0 = pulses;
        u_host.frame({d, a, c}, n, rx, oe);
        for (int i = 0; i < 20 && pulses == p0; i++) @(posedge core_clk);
        #1;
        `CHK(sdo_oe, 1'b0)
        if (commit) begin
            `CHK(pulses - p0, 1)
            `CHK(reg_wr_index, a)
            `CHK(reg_wr_data, d)
        end else begin
            `CHK(pulses - p0, 0)
        end
    endtask

    // power-on delay holds the core in reset for the set count
    task automatic t_por;
        int n;
        n = 0;
        // look after the edge, not in the time step that launches it
        #1;
        `CHK(core_reset, 1'b1)
        while (core_reset !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(n >= POR && n <= POR + 2, 1'b1)
    endtask

    // plain writes; the first frame after reset was never addressed
    task automatic t_write;
        send(30'h2ABCDEF1, 7'h02, 3'h7, 40, 1);
        `CHK(oe, 1'b0)
        send(30'h15555555, 7'h03, 3'h7, 40, 1);
    endtask

    // two-frame reads through the pointer, back to back, then the id word
    task automatic t_read;
        send(30'h2, 7'h00, 3'h7, 40, 1);
        send(30'h3, 7'h00, 3'h7, 40, 1);
        `CHK(oe, 1'b1)
        `CHK(rx, {30'h2ABCDEF1, 7'h02, 3'h7})
        send(30'h0, 7'h00, 3'h7, 40, 1);
        `CHK(rx, {30'h15555555, 7'h03, 3'h7})
        send(30'h0, 7'h00, 3'h7, 40, 1);
        `CHK(rx, {ID, 8'h00, 7'h00, 3'h7})
    endtask

    // wrong chip code and a short frame are dropped and arm nothing
    task automatic t_refuse;
        send(30'h123, 7'h01, 3'h6, 40, 0);
        send(30'h1, 7'h00, 3'h7, 40, 1);
        `CHK(oe, 1'b0)
        send(30'h456, 7'h01, 3'h7, 39, 0);
        send(30'h1, 7'h00, 3'h7, 40, 1);
        `CHK(oe, 1'b0)
        send(30'h1, 7'h00, 3'h7, 40, 1);
        `CHK(rx, {30'h0, 7'h01, 3'h7})
    endtask

    // soft reset by 80h then 00h clears a written register
    task automatic t_soft;
        send(30'h3C3C, 7'h01, 3'h7, 40, 1);
        send(30'h80, 7'h00, 3'h7, 40, 1);
        `CHK(core_reset, 1'b1)
        send(30'h00, 7'h00, 3'h7, 40, 1);
        `CHK(core_reset, 1'b0)
        send(30'h01, 7'h00, 3'h7, 40, 1);
        send(30'h01, 7'h00, 3'h7, 40, 1);
        `CHK(rx, {30'h0, 7'h01, 3'h7})
    endtask

    // main sequence: reset for two cycles, then each scenario in turn
    initial begin
        bad_count   = 0;
        checks_done = 0;
        pulses      = 0;
        resetn     <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        t_por;
        t_write;
        t_read;
        t_refuse;
        t_soft;
        test_done;
    end

    // cuts a hang short well above the expected run length
    initial begin
        #200000;
        bad_count++;
        test_done;
    end
endmodule
